// ---- plf_pkg.sv ----
// plf_pkg: constants, types and tap decoding shared by the
// programmable length shift register generator and its feedback unit.
// assumes one 10 MHz clock and a 32-bit apb register window.
package plf_pkg;

  // ----------------------------------------------------------------
  // geometry and timing
  // ----------------------------------------------------------------
  localparam int unsigned STAGES      = 32;          // physical stages
  localparam int unsigned LEN_W       = 5;           // length input width
  localparam logic [4:0]  LEN_MIN     = 5'h01;       // shortest length code
  localparam logic [4:0]  LEN_MAX     = 5'h1f;       // longest length code
  localparam logic [4:0]  LEN_RST     = 5'h1f;       // length after reset
  localparam int unsigned SEED_CYCLES = 32;          // serial seed length
  localparam logic [31:0] SHREG_RST   = 32'h00000001; // never a lock state
  localparam int unsigned CLK_HZ      = 10000000;    // clock rate

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 12;
  localparam logic [11:0] CTRL_ADDR   = 12'h000;     // control
  localparam logic [11:0] STATUS_ADDR = 12'h004;     // live status
  localparam logic [11:0] STATE_ADDR  = 12'h008;     // stage contents
  localparam int unsigned CTRL_OE_BIT = 0;           // output enable
  localparam logic        CTRL_OE_RST = 1'b1;        // enabled at reset
  localparam int unsigned ST_LEN_LSB  = 0;           // applied length
  localparam int unsigned ST_LOAD_BIT = 8;           // seeding in progress
  localparam int unsigned ST_OUT_BIT  = 9;           // last output bit

  // live status gathered for readback
  typedef struct packed {
    logic       out_bit;   // last sequence bit
    logic       loading;   // load seen at last edge
    logic [4:0] length;    // applied length code
  } plf_status_s;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // length code 0 is outside the legal range: treat it as 1
  function automatic logic [4:0] plf_clamp_len(input logic [4:0] len);
    plf_clamp_len = (len < LEN_MIN) ? LEN_MIN : len;
  endfunction : plf_clamp_len

  // maximal length tap mask for size len+1; bit k is stage k
  function automatic logic [31:0] plf_tap_mask(input logic [4:0] len);
    case (plf_clamp_len(len))
      5'h01: plf_tap_mask = 32'h00000003;
      5'h02: plf_tap_mask = 32'h00000006;
      5'h03: plf_tap_mask = 32'h0000000c;
      5'h04: plf_tap_mask = 32'h00000014;
      5'h05: plf_tap_mask = 32'h00000030;
      5'h06: plf_tap_mask = 32'h00000060;
      5'h07: plf_tap_mask = 32'h000000b8;
      5'h08: plf_tap_mask = 32'h00000110;
      5'h09: plf_tap_mask = 32'h00000240;
      5'h0a: plf_tap_mask = 32'h00000500;
      5'h0b: plf_tap_mask = 32'h00000829;
      5'h0c: plf_tap_mask = 32'h0000100d;
      5'h0d: plf_tap_mask = 32'h00002015;
      5'h0e: plf_tap_mask = 32'h00006000;
      5'h0f: plf_tap_mask = 32'h0000d008;
      5'h10: plf_tap_mask = 32'h00012000;
      5'h11: plf_tap_mask = 32'h00020400;
      5'h12: plf_tap_mask = 32'h00040023;
      5'h13: plf_tap_mask = 32'h00090000;
      5'h14: plf_tap_mask = 32'h00140000;
      5'h15: plf_tap_mask = 32'h00300000;
      5'h16: plf_tap_mask = 32'h00420000;
      5'h17: plf_tap_mask = 32'h00e10000;
      5'h18: plf_tap_mask = 32'h01200000;
      5'h19: plf_tap_mask = 32'h02000023;
      5'h1a: plf_tap_mask = 32'h04000013;
      5'h1b: plf_tap_mask = 32'h09000000;
      5'h1c: plf_tap_mask = 32'h14000000;
      5'h1d: plf_tap_mask = 32'h20000029;
      5'h1e: plf_tap_mask = 32'h48000000;
      default: plf_tap_mask = 32'h80200003;
    endcase
  endfunction : plf_tap_mask

endpackage : plf_pkg

// ---- plf_feedback.sv ----
// plf_feedback: combinational feedback bit for the shift register.
// assumes the caller holds the stage contents in a register and
// presents the length code that applies at the coming edge.
module plf_feedback #(
  parameter bit XNOR_FB = 1'b0  // build-time feedback flavour
) (
  input  wire logic [31:0] stages,   // current stage contents
  input  wire logic [4:0]  length,   // length code for this edge
  output logic             fb_bit    // bit for stage 0
);

  // ----------------------------------------------------------------
  // tap selection
  // ----------------------------------------------------------------
  // maximal taps give the full period
  // taps follow the length code, so a new code retunes at once
  wire logic [31:0] tap_mask = plf_pkg::plf_tap_mask(length);
  // only the tapped stages take part
  wire logic [31:0] tapped   = stages & tap_mask;
  // parity of the tapped stages
  wire logic        parity   = ^tapped;

  // ----------------------------------------------------------------
  // feedback combine
  // ----------------------------------------------------------------
  // xor or xnor combine
  assign fb_bit = XNOR_FB ? ~parity : parity;

endmodule : plf_feedback

// ---- plf_lfsr.sv ----
// plf_lfsr: programmable length pseudorandom bit generator with a
// serial seed load and a small apb window for control and status.
// assumes length, load and initial_seed_value come from user logic
// on clk, and that an apb master on clk reaches the registers.
//
// The APB register port and the register addresses were chosen for this implementation.

// Functional notes
// - size is length code plus one
// - size m repeats every 2^m-1 bits
// - length sampled each edge, taps follow
// - load gives plain 32-stage shift
// - seed shifts in one bit per edge
// - length ignored while load is high
// - first edge after load starts sequence
// - tapped stages combined and fed back
// - xor default, xnor at build time
module plf_lfsr #(
  parameter bit XNOR_FB = 1'b0  // 0 xor feedback, 1 xnor feedback
) (
  input  wire logic        clk,                 // 10 MHz clock
  input  wire logic        rstn,                // async reset, low
  input  wire logic [4:0]  length,              // size minus one
  input  wire logic        load,                // seeding in progress
  input  wire logic        initial_seed_value,  // serial seed bit
  output logic             lfsr_out,            // sequence bit
  input  wire logic        psel,                // apb select
  input  wire logic        penable,             // apb access phase
  input  wire logic        pwrite,              // apb direction
  input  wire logic [11:0] paddr,               // apb byte address
  input  wire logic [31:0] pwdata,              // apb write data
  output logic [31:0]      prdata,              // apb read data
  output logic             pready,              // apb ready
  output logic             pslverr              // apb error
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;  // first release stage
  logic rst_n_reg;     // reset used by the rest of the design

  // the stages come up at a non-lock value, so the sequence
  // cannot stick after reset whatever the feedback flavour
  // assert at once, release after two clean edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0]         shreg_reg;    // stage contents
  logic [31:0]         shreg_next;   // stage contents after the edge
  logic [4:0]          len_reg;      // applied length code
  logic [4:0]          len_next;     // length code for this edge
  logic                out_reg;      // registered sequence bit
  logic                out_next;     // sequence bit after the edge
  logic                load_reg;     // load seen at last edge
  logic                oe_reg;       // software output enable
  logic [31:0]         prdata_reg;   // read data held for access
  logic                fb_bit;       // feedback from the tap unit
  plf_pkg::plf_status_s status;      // gathered live status

  // ----------------------------------------------------------------
  // length capture
  // ----------------------------------------------------------------
  // sample length when not loading
  assign len_next = load ? len_reg : plf_pkg::plf_clamp_len(length);

  // applied length register
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      len_reg <= plf_pkg::LEN_RST;
    end else begin
      len_reg <= len_next;
    end
  end

  // ----------------------------------------------------------------
  // feedback
  // ----------------------------------------------------------------
  // taps follow the code sampled at this very edge, so the first
  // edge after load already runs at the new size
  plf_feedback #(
    .XNOR_FB (XNOR_FB)
  ) u_feedback (
    .stages (shreg_reg),
    .length (len_next),
    .fb_bit (fb_bit)
  );

  // ----------------------------------------------------------------
  // shift path
  // ----------------------------------------------------------------
  // load: plain 32-stage shift, no feedback
  // after load, feedback resumes from seed
  assign shreg_next = load ? {shreg_reg[30:0], initial_seed_value}
                           : {shreg_reg[30:0], fb_bit};

  // output stage is length code, size code plus one; stage 31 while loading
  assign out_next = load ? shreg_next[plf_pkg::STAGES - 1]
                         : shreg_next[len_next];

  // stage, output and load history registers
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      shreg_reg <= plf_pkg::SHREG_RST;
      out_reg   <= 1'b0;
      load_reg  <= 1'b0;
    end else begin
      shreg_reg <= shreg_next;
      out_reg   <= out_next;
      load_reg  <= load;
    end
  end

  // software may silence the output without stopping the sequence
  assign lfsr_out = out_reg & oe_reg;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // decode of the three mapped words
  wire logic hit_ctrl   = (paddr == plf_pkg::CTRL_ADDR);
  wire logic hit_status = (paddr == plf_pkg::STATUS_ADDR);
  wire logic hit_state  = (paddr == plf_pkg::STATE_ADDR);
  wire logic hit_any    = hit_ctrl | hit_status | hit_state;
  // setup phase: read data is latched here
  wire logic setup_ph   = psel & ~penable;
  // access phase: every access completes in one cycle
  wire logic access_ph  = psel & penable;
  wire logic wr_ctrl    = access_ph & pwrite & hit_ctrl;

  // live status word
  assign status.out_bit = out_reg;
  assign status.loading = load_reg;
  assign status.length  = len_reg;

  // read selection, unmapped words read as zero
  wire logic [31:0] rd_ctrl   = {31'h00000000, oe_reg};
  wire logic [31:0] rd_status = {22'h000000, status.out_bit,
                                 status.loading, 3'h0, status.length};
  wire logic [31:0] rd_mux    = hit_ctrl   ? rd_ctrl   :
                                hit_status ? rd_status :
                                hit_state  ? shreg_reg : 32'h00000000;

  // control register and read data register
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      oe_reg     <= plf_pkg::CTRL_OE_RST;
      prdata_reg <= 32'h00000000;
    end else begin
      if (wr_ctrl) begin
        oe_reg <= pwdata[plf_pkg::CTRL_OE_BIT];
      end
      if (setup_ph && !pwrite) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  // writes to the status and stage words are dropped quietly;
  // only addresses outside the three words raise an error
  // no wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~hit_any;
  assign prdata  = prdata_reg;

  // ----------------------------------------------------------------
  // assertion helpers
  // ----------------------------------------------------------------
  logic [5:0] load_cnt_reg;  // consecutive load edges, saturating

  // the counter saturates well above the seed length, so a long
  // load keeps the seed check armed
  // count unbroken load edges for the seed check
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      load_cnt_reg <= 6'h00;
    end else if (!load) begin
      load_cnt_reg <= 6'h00;
    end else if (load_cnt_reg != 6'h3f) begin
      load_cnt_reg <= load_cnt_reg + 6'h01;
    end
  end

  // reference parity, worked out apart from the tap unit
  wire logic ref_fb = (^(shreg_reg & plf_pkg::plf_tap_mask(
                         plf_pkg::plf_clamp_len(length)))) ^ XNOR_FB;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // every check is off while the internal reset is low, and checks
  // that look one edge ahead, except len_hold_a and release_run_a, also skip the edge that releases it
  // applied length stays legal
  len_legal_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    (len_reg >= plf_pkg::LEN_MIN))
    else $error("applied length code out of range");

  // size two repeats every three bits
  short_period_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    (!load && length == 5'h01)[*4] |-> shreg_reg[1:0] == $past(shreg_reg[1:0], 3))
    else $error("size two sequence does not repeat after three bits");

  len_capture_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    rst_n_reg && !load |=> len_reg == plf_pkg::plf_clamp_len($past(length)))
    else $error("length not captured at the edge");

  load_shift_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    rst_n_reg && load |=> shreg_reg == {$past(shreg_reg[30:0]), $past(initial_seed_value)})
    else $error("stages did not shift plainly during load");

  // 32 seed bits reach last stage
  seed_arrive_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    load_cnt_reg >= 6'(plf_pkg::SEED_CYCLES)
      |-> shreg_reg[31] == $past(initial_seed_value, plf_pkg::SEED_CYCLES))
    else $error("seed bit missing from last stage");

  len_hold_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    load |=> $stable(len_reg))
    else $error("length changed while load was high");

  fb_enter_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    rst_n_reg && !load |=> shreg_reg[0] == $past(ref_fb))
    else $error("stage 0 did not take the feedback bit");

  // first edge after load runs feedback
  release_run_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    $fell(load) |-> ##1 shreg_reg[0] == $past(ref_fb))
    else $error("first edge after load did not use feedback");

  out_stage_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    !load_reg |-> out_reg == shreg_reg[len_reg])
    else $error("output not taken from the last active stage");

  // output from stage 31 while loading
  out_load_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    load_reg |-> out_reg == shreg_reg[31])
    else $error("output not taken from stage 31 during load");

  // size three repeats every seven bits
  mid_period_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    (!load && length == 5'h02)[*8] |-> shreg_reg[2:0] == $past(shreg_reg[2:0], 7))
    else $error("size three sequence does not repeat after seven bits");

  // code zero runs as the shortest size
  zero_len_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    rst_n_reg && !load && length == 5'h00 |=> len_reg == plf_pkg::LEN_MIN)
    else $error("length code zero not applied as the shortest size");

  // each seed bit enters stage 0
  seed_enter_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    rst_n_reg && load |=> shreg_reg[0] == $past(initial_seed_value))
    else $error("seed bit did not enter stage 0");

  release_len_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    rst_n_reg && $fell(load) |=> len_reg == plf_pkg::plf_clamp_len($past(length)))
    else $error("first edge after load did not apply the length");

  // control write lands at the access edge
  ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    rst_n_reg && psel && penable && pwrite && paddr == plf_pkg::CTRL_ADDR
      |=> oe_reg == $past(pwdata[plf_pkg::CTRL_OE_BIT]))
    else $error("control write did not land");

  // error only shows in the access phase
  err_access_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    pslverr |-> psel && penable)
    else $error("bus error outside the access phase");

  // read data changes only after a read setup
  rdata_hold_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    rst_n_reg && !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed without a read setup");

  // status read shows applied length and load history
  status_len_a: assert property (@(posedge clk) disable iff (!rst_n_reg)
    rst_n_reg && psel && !penable && !pwrite && paddr == plf_pkg::STATUS_ADDR
      |=> prdata[plf_pkg::ST_LEN_LSB +: 5] == $past(len_reg)
          && prdata[plf_pkg::ST_LOAD_BIT] == $past(load_reg))
    else $error("status read does not show the applied length");

endmodule : plf_lfsr

// ---- plf_user_model.sv ----
// plf_user_model: user logic that seeds the generator and sets its length.
// assumes each task is entered in the time step of a rising clk edge.
module plf_user_model (
  input  wire logic clk,                // system clock
  output logic [4:0] length,            // length code
  output logic       load,              // seeding strobe
  output logic       initial_seed_value // serial seed bit
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // time zero levels
  // ----------------------------------------------------------------
  initial begin
    length             = 5'h1f;
    load               = 1'b0;
    initial_seed_value = 1'b0;
  end

  // ----------------------------------------------------------------
  // seeding and free running
  // ----------------------------------------------------------------
  // msb first, one bit per edge
  // load held through the 32nd edge
  task automatic seed(input logic [31:0] s);
    for (int i = 0; i < 32; i++) begin
      load               <= 1'b1;
      initial_seed_value <= s[31-i];
      length             <= i[4:0];  // wanders, must be ignored
      @(posedge clk);
    end
  endtask : seed

  // one edge at length len; the unused seed line keeps toggling
  task automatic run(input logic [4:0] len);
    load               <= 1'b0;
    length             <= len;
    initial_seed_value <= ~initial_seed_value;
    @(posedge clk);
  endtask : run
endmodule : plf_user_model

// ---- plf_lfsr_test.sv ----
// plf_lfsr_test: self-checking bench for the length-programmable generator.
// assumes plf_pkg, the design and plf_user_model are compiled first.
module plf_lfsr_test;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [31:0] SEED_A = 32'h9e3779b9;  // first seed word
  localparam logic [31:0] SEED_B = 32'hc3a55a3d;  // low bits nonzero
  logic        clk = 1'b0;                // 100 ns clock
  logic        rstn = 1'b0;               // async reset, low
  logic [4:0]  length;                    // from user model
  logic        load;                      // from user model
  logic        initial_seed_value;        // from user model
  logic        lfsr_out;                  // sequence bit
  logic        lfsr_x_out;                // sequence bit, xnor build
  logic        psel = 1'b0;               // apb select
  logic        penable = 1'b0;            // apb access phase
  logic        pwrite = 1'b0;             // apb direction
  logic [11:0] paddr = 12'h000;           // apb address
  logic [31:0] pwdata = 32'h00000000;     // apb write data
  logic [31:0] prdata;                    // apb read data
  logic        pready;                    // apb ready
  logic        pslverr;                   // apb error
  logic        seen [0:299];              // output bit after each edge
  logic        seen_x [0:299];            // same for the xnor build
  int          n_mismatch = 0;            // failed compares
  int          samples_checked = 0;       // all compares
  int          cyc = 0;                   // timeout counter

  plf_lfsr dut_u (.clk, .rstn, .length, .load, .initial_seed_value, .lfsr_out,
                  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  plf_user_model user_u (.clk, .length, .load, .initial_seed_value);
  // second build with xnor feedback, fed the same stimulus
  plf_lfsr #(.XNOR_FB(1'b1)) dut_xnor_u (.clk, .rstn, .length, .load, .initial_seed_value,
                  .lfsr_out(lfsr_x_out), .psel, .penable, .pwrite, .paddr, .pwdata,
                  .prdata(), .pready(), .pslverr());

  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  always #50 clk = ~clk;

  // the run needs about 590 cycles, so this only cuts a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic cmp_bit(input string what, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : cmp_word

  // one apb transfer; held until pready is seen at an access edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    cmp_bit("pready", 1'b1, pready);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // records the output bit settled after each of the next n edges
  task automatic watch(input int n);
    @(posedge clk);
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      seen[k] = lfsr_out;
      seen_x[k] = lfsr_x_out;
    end
  endtask : watch

  task automatic end_sim;
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] rd;
    logic        err;
    apb(1'b0, plf_pkg::CTRL_ADDR, 32'h00000000, rd, err);
    cmp_word("ctrl reset", 32'h00000001, rd);
    apb(1'b0, plf_pkg::STATUS_ADDR, 32'h00000000, rd, err);
    cmp_word("status length", 32'h0000001f, rd & 32'h000001ff);
    cmp_bit("status err", 1'b0, err);
    apb(1'b1, plf_pkg::STATE_ADDR, 32'hffffffff, rd, err);
    cmp_bit("state write err", 1'b0, err);
    apb(1'b0, 12'h00c, 32'h00000000, rd, err);
    cmp_word("unmapped data", 32'h00000000, rd);
    cmp_bit("unmapped err", 1'b1, err);
    $display("test regs done");
  endtask : t_regs

  // back to back seeds, then a new length at every edge
  task automatic t_seed;
    logic [4:0] lens [4] = '{5'h00, 5'h02, 5'h1f, 5'h08};
    int         pos [4]  = '{0, 0, 28, 4};
    fork
      begin
        user_u.seed(SEED_A);
        user_u.seed(SEED_B);
        for (int j = 0; j < 4; j++) user_u.run(lens[j]);
      end
      watch(68);
    join
    @(posedge clk);
    for (int k = 1; k < 32; k++) cmp_bit("load shift", SEED_A[31-k], seen[31+k]);
    cmp_bit("load last", SEED_B[31], seen[63]);
    for (int j = 0; j < 4; j++) cmp_bit("resized out", SEED_B[pos[j]], seen[64+j]);
    $display("test seed done");
  endtask : t_seed

  // a maximal sequence of size len+1 repeats and holds 2^len ones;
  // the xnor build holds one less, being the complement of such a run
  task automatic t_period(input logic [4:0] len);
    int         p;
    int         ones;
    int         ones_x;
    logic [1:0] s;
    logic [1:0] sx;
    p = (1 << (int'(len) + 1)) - 1;
    ones = 0;
    ones_x = 0;
    s = SEED_B[1:0];
    sx = SEED_B[1:0];
    fork
      begin
        user_u.seed(SEED_B);
        repeat (2 * p) user_u.run(len);
      end
      watch(32 + 2 * p);
    join
    @(posedge clk);
    for (int i = 0; i < p; i++) begin
      cmp_bit("period", seen[32+i], seen[32+i+p]);
      cmp_bit("xnor period", seen_x[32+i], seen_x[32+i+p]);
      ones += int'(seen[32+i] === 1'b1);
      ones_x += int'(seen_x[32+i] === 1'b1);
    end
    cmp_word("ones count", 32'((p + 1) / 2), 32'(ones));
    cmp_word("xnor ones count", 32'((p - 1) / 2), 32'(ones_x));
    // size two: stage1 xor stage0 is the only maximal feedback
    if (len == 5'h01) begin
      for (int i = 0; i < 6; i++) begin
        s = {s[0], s[1] ^ s[0]};
        sx = {sx[0], ~(sx[1] ^ sx[0])};
        cmp_bit("xor feedback", s[1], seen[32+i]);
        cmp_bit("xnor feedback", sx[1], seen_x[32+i]);
      end
    end
    $display("test period %0d done", p);
  endtask : t_period

  task automatic t_oe;
    logic [31:0] rd;
    logic        err;
    int          ones;
    ones = 0;
    apb(1'b1, plf_pkg::CTRL_ADDR, 32'h00000000, rd, err);
    watch(8);
    for (int k = 0; k < 8; k++) cmp_bit("masked out", 1'b0, seen[k]);
    @(posedge clk);
    apb(1'b1, plf_pkg::CTRL_ADDR, 32'h00000001, rd, err);
    watch(16);
    for (int k = 0; k < 16; k++) ones += int'(seen[k] === 1'b1);
    cmp_bit("unmasked out", 1'b1, ones > 0);
    $display("test oe done");
  endtask : t_oe

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_seed();
    t_period(5'h01);
    t_period(5'h02);
    t_period(5'h04);
    t_period(5'h06);
    t_oe();
    end_sim();
  end
endmodule : plf_lfsr_test
